// *** inc/sfe_consts.vh ***
// Constants shared by the serial flash erase and program sequencer.
`ifndef SFE_CONSTS_VH
`define SFE_CONSTS_VH

// Command opcodes.
`define SFE_OP_BLOCK_ERASE 8'h50
`define SFE_OP_SECTOR_ERASE 8'h7c
`define SFE_OP_PROG_BUF1 8'h82
`define SFE_OP_PROG_BUF2 8'h85

// Four-byte chip erase sequence.
`define SFE_CHIP_B0 8'hc7
`define SFE_CHIP_B1 8'h94
`define SFE_CHIP_B2 8'h80
`define SFE_CHIP_B3 8'h9a

// Byte positions within a frame.
`define SFE_BYTE_OPC 3'h0
`define SFE_BYTE_A2 3'h1
`define SFE_BYTE_A1 3'h2
`define SFE_BYTE_A0 3'h3
`define SFE_BYTE_DATA 3'h4
`define SFE_BIT_LAST 3'h7

// Address field positions in the 24-bit address word.
`define SFE_STD_PAGE_HI 19
`define SFE_STD_PAGE_LO 9
`define SFE_BIN_PAGE_HI 18
`define SFE_BIN_PAGE_LO 8

// Last byte address of each buffer format.
`define SFE_STD_BUF_LAST 9'h107
`define SFE_BIN_BUF_LAST 9'h0ff

// Array geometry in pages.
`define SFE_PAGES_BLOCK 12'h008
`define SFE_PAGES_SECTOR 12'h100
`define SFE_PAGES_SECT0B 12'h0f8
`define SFE_PAGES_CHIP 12'h800
`define SFE_SECT0B_FIRST 11'h008

// Protection mask bit positions: 0a, 0b, then sectors 1 to 7.
`define SFE_MASK_0A 0
`define SFE_MASK_0B 1
`define SFE_MASK_S1 2

// Clock rate and self-timed durations in microseconds.
`define SFE_CLK_MHZ 100
`define SFE_BLOCK_ERASE_TIME_US 45000
`define SFE_SECTOR_ERASE_TIME_US 1600000
`define SFE_CHIP_ERASE_TIME_US 10000000
`define SFE_PAGE_ERASE_TIME_US 15000
`define SFE_PAGE_PROG_TIME_US 3000

`endif

// *** rtl/sfe_sequencer.v ***
// Serial command decoder and self-timed sequencer for erase and buffered page program.
//
// Function
// RL1 - Standard block erase: opcode 50h, block from page_addr[10:3], other bits ignored.
// RL2 - Binary block erase: opcode 50h, block bits at binary address 18 to 11.
// RL3 - Block chosen by eight upper page bits; blocks 0-255, eight pages each.
// RL4 - Select release after block erase erases eight pages, busy until done.
// RL5 - Standard sector 0a/0b erase: opcode 7Ch, page_addr[10:3] carries the selection.
// RL6 - Standard sector 1-7 erase: opcode 7Ch, page_addr[10:8] select the sector.
// RL7 - Binary sector 0a/0b erase: opcode 7Ch, address bits 18 to 11.
// RL8 - Binary higher sector erase: opcode 7Ch, address bits 18 to 16.
// RL9 - One sector per command; nonzero top bits pick 1-7, else page bit 3 picks 0a/0b.
// RL10 - Select release after sector erase erases that sector, busy meanwhile.
// RL11 - Chip erase is the byte sequence c7h 94h 80h 9ah, no address.
// RL12 - Bytes after the chip erase sequence are ignored until select releases.
// RL13 - Select release after chip erase runs a timed whole-array erase, busy meanwhile.
// RL14 - Chip erase skips protected or locked sectors.
// RL15 - Write protect raised during erase takes effect only after the erase ends.
// RL16 - Standard program through buffer: 82h/85h, eleven page bits, nine byte bits.
// RL17 - Binary program through buffer: same opcodes, page at 18 to 8, eight byte bits.
// RL18 - Data bytes fill the chosen buffer from the start address, wrapping at its end.
// RL19 - Select release after program erases the page to ones, then programs it.
// RL20 - Only complete commands at a byte boundary start work; others are dropped.
// RL21 - Host waits for busy to clear before another erase or program.
`timescale 1ns/1ps
`default_nettype none
`include "sfe_consts.vh"

module sfe_sequencer #(
  parameter [31:0] BLOCK_ERASE_CYCLES = `SFE_BLOCK_ERASE_TIME_US * `SFE_CLK_MHZ,
  parameter [31:0] SECTOR_ERASE_CYCLES = `SFE_SECTOR_ERASE_TIME_US * `SFE_CLK_MHZ,
  parameter [31:0] CHIP_ERASE_CYCLES = `SFE_CHIP_ERASE_TIME_US * `SFE_CLK_MHZ,
  parameter [31:0] PAGE_ERASE_CYCLES = `SFE_PAGE_ERASE_TIME_US * `SFE_CLK_MHZ,
  parameter [31:0] PAGE_PROG_CYCLES = `SFE_PAGE_PROG_TIME_US * `SFE_CLK_MHZ
) (
  // Clock and reset.
  input wire clock,
  input wire reset,
  // Serial link pins from the host.
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  // Configuration from same-clock logic.
  input wire binary_page_mode,
  input wire sect_prot_sw_en,
  input wire [8:0] sect_prot_mask,
  input wire [8:0] sect_lock_mask,
  // Status.
  output reg status_busy_r,
  output reg prot_active_r,
  // Buffer write port.
  output reg buf_wr_en_r,
  output reg buf_wr_sel_r,
  output reg [8:0] buf_wr_addr_r,
  output reg [7:0] buf_wr_data_r,
  // Array operation requests.
  output reg arr_erase_go_r,
  output reg arr_prog_go_r,
  output reg [10:0] arr_first_page_r,
  output reg [11:0] arr_page_count_r,
  output reg [8:0] arr_skip_mask_r,
  output reg arr_buf_sel_r
);

  // One-hot sequencer states.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ERASE = 3'b010;
  localparam [2:0] ST_PROG = 3'b100;

  // Synchronisers for the pins; first stages feed only second stages.
  reg cs_s1_r, cs_s2_r, cs_s3_r;
  reg sck_s1_r, sck_s2_r, sck_s3_r;
  reg si_s1_r, si_s2_r;
  reg wp_s1_r, wp_s2_r;

  // Frame receiver state.
  reg [7:0] shift_r;
  reg [2:0] bit_cnt_r;
  reg [2:0] byte_cnt_r;
  reg [7:0] opcode_r;
  reg [23:0] addr_r;
  reg chip_ok_r;
  reg accept_r;
  reg [8:0] wr_ptr_r;

  // Sequencer state.
  reg [2:0] st_r;
  reg prog_pending_r;
  reg wp_hold_r;
  reg tmr_load_r;
  reg [31:0] tmr_cycles_r;
  wire tmr_done;

  wire sck_rise = sck_s2_r & ~sck_s3_r;
  wire cs_fall = ~cs_s2_r & cs_s3_r;
  wire cs_rise = cs_s2_r & ~cs_s3_r;
  wire [7:0] byte_in = {shift_r[6:0], si_s2_r};
  wire byte_done = sck_rise & ~cs_s2_r & (bit_cnt_r == `SFE_BIT_LAST);
  wire is_prog = (opcode_r == `SFE_OP_PROG_BUF1) | (opcode_r == `SFE_OP_PROG_BUF2);
  wire frame_whole = (bit_cnt_r == 3'h0) & (byte_cnt_r == `SFE_BYTE_DATA);
  wire idle = st_r[0];
  // A launch needs a whole accepted frame that carries a command this block runs.
  // An unknown opcode must not even flash busy, so it is filtered here.
  wire known_op = chip_ok_r | is_prog | (opcode_r == `SFE_OP_BLOCK_ERASE) | (opcode_r == `SFE_OP_SECTOR_ERASE);
  wire launch = cs_rise & accept_r & frame_whole & known_op; // RL20

  // Page number from the address word in either page-size format.
  function [10:0] page_of;
    input [23:0] a;
    input bin;
    begin
      if (bin) begin
        page_of = a[`SFE_BIN_PAGE_HI:`SFE_BIN_PAGE_LO]; // RL17
      end else begin
        page_of = a[`SFE_STD_PAGE_HI:`SFE_STD_PAGE_LO]; // RL16
      end
    end
  endfunction

  // Next buffer write position, wrapping past the last byte.
  function [8:0] next_ptr;
    input [8:0] p;
    input bin;
    reg [8:0] last;
    begin
      last = bin ? `SFE_BIN_BUF_LAST : `SFE_STD_BUF_LAST;
      next_ptr = (p >= last) ? 9'h000 : p + 9'h001; // RL18
    end
  endfunction

  // Target page and skip mask seen by the sequencer at launch.
  wire [10:0] pg = page_of(addr_r, binary_page_mode);
  wire [8:0] skip = sect_lock_mask | (prot_active_r ? sect_prot_mask : 9'h000); // RL14

  // Pin synchronisers.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sck_s1_r <= sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      si_s1_r <= si;
      si_s2_r <= si_s1_r;
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
    end
  end

  // Frame receiver: shifts bits, collects opcode and address, writes data to the buffer.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      opcode_r <= 8'h00;
      addr_r <= 24'h000000;
      chip_ok_r <= 1'b0;
      accept_r <= 1'b0;
      wr_ptr_r <= 9'h000;
      buf_wr_en_r <= 1'b0;
      buf_wr_sel_r <= 1'b0;
      buf_wr_addr_r <= 9'h000;
      buf_wr_data_r <= 8'h00;
    end else begin
      buf_wr_en_r <= 1'b0;
      if (cs_fall) begin
        // Commands that open while an operation runs are ignored whole.
        shift_r <= 8'h00;
        bit_cnt_r <= 3'h0;
        byte_cnt_r <= 3'h0;
        chip_ok_r <= 1'b0;
        accept_r <= idle; // RL21
      end else if (sck_rise & ~cs_s2_r) begin
        shift_r <= byte_in;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (byte_done) begin
          if (byte_cnt_r != `SFE_BYTE_DATA) begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
          end
          case (byte_cnt_r)
            `SFE_BYTE_OPC: begin
              opcode_r <= byte_in;
              chip_ok_r <= (byte_in == `SFE_CHIP_B0); // RL11
            end
            `SFE_BYTE_A2: begin
              addr_r <= {addr_r[15:0], byte_in};
              chip_ok_r <= chip_ok_r & (byte_in == `SFE_CHIP_B1); // RL11
            end
            `SFE_BYTE_A1: begin
              addr_r <= {addr_r[15:0], byte_in};
              chip_ok_r <= chip_ok_r & (byte_in == `SFE_CHIP_B2); // RL11
            end
            `SFE_BYTE_A0: begin
              addr_r <= {addr_r[15:0], byte_in};
              chip_ok_r <= chip_ok_r & (byte_in == `SFE_CHIP_B3); // RL11
              if (binary_page_mode) begin
                wr_ptr_r <= {1'b0, byte_in}; // RL17
              end else begin
                wr_ptr_r <= {addr_r[0], byte_in}; // RL16
              end
            end
            default: begin // RL12
              // Data phase; chip erase flag is left alone so trailing bytes do nothing.
              if (is_prog & accept_r) begin
                buf_wr_en_r <= 1'b1; // RL18
                buf_wr_sel_r <= (opcode_r == `SFE_OP_PROG_BUF2);
                buf_wr_addr_r <= wr_ptr_r;
                buf_wr_data_r <= byte_in;
                wr_ptr_r <= next_ptr(wr_ptr_r, binary_page_mode); // RL18
              end
            end
          endcase
        end
      end
    end
  end

  // Sequencer: launches on select release and walks the timed phases.
  always @(posedge clock or posedge reset) begin : seq
    if (reset) begin
      st_r <= ST_IDLE;
      prog_pending_r <= 1'b0;
      wp_hold_r <= 1'b0;
      tmr_load_r <= 1'b0;
      tmr_cycles_r <= 32'h00000000;
      arr_erase_go_r <= 1'b0;
      arr_prog_go_r <= 1'b0;
      arr_first_page_r <= 11'h000;
      arr_page_count_r <= 12'h000;
      arr_skip_mask_r <= 9'h000;
      arr_buf_sel_r <= 1'b0;
      status_busy_r <= 1'b0;
      prot_active_r <= 1'b0;
    end else begin
      tmr_load_r <= 1'b0;
      arr_erase_go_r <= 1'b0;
      arr_prog_go_r <= 1'b0;
      // Write protect is sampled only between operations.
      if (idle) begin
        wp_hold_r <= ~wp_s2_r; // RL15
      end
      prot_active_r <= sect_prot_sw_en | wp_hold_r;
      status_busy_r <= ~(idle & ~launch);
      case (st_r)
        ST_IDLE: begin
          // Only a whole command ending on a byte boundary starts work.
          if (launch) begin // RL20
            arr_skip_mask_r <= skip;
            arr_buf_sel_r <= (opcode_r == `SFE_OP_PROG_BUF2);
            prog_pending_r <= 1'b0;
            if (chip_ok_r) begin
              arr_first_page_r <= 11'h000; // RL13
              arr_page_count_r <= `SFE_PAGES_CHIP;
              tmr_cycles_r <= CHIP_ERASE_CYCLES;
              arr_erase_go_r <= 1'b1;
              tmr_load_r <= 1'b1;
              st_r <= ST_ERASE;
            end else if (opcode_r == `SFE_OP_BLOCK_ERASE) begin
              arr_first_page_r <= {pg[10:3], 3'b000}; // RL1 RL2 RL3
              arr_page_count_r <= `SFE_PAGES_BLOCK; // RL4
              tmr_cycles_r <= BLOCK_ERASE_CYCLES;
              arr_erase_go_r <= 1'b1;
              tmr_load_r <= 1'b1;
              st_r <= ST_ERASE;
            end else if (opcode_r == `SFE_OP_SECTOR_ERASE) begin
              if (pg[10:8] != 3'b000) begin
                arr_first_page_r <= {pg[10:8], 8'h00}; // RL6 RL8 RL9
                arr_page_count_r <= `SFE_PAGES_SECTOR;
              end else if (pg[3]) begin
                arr_first_page_r <= `SFE_SECT0B_FIRST; // RL5 RL7 RL9
                arr_page_count_r <= `SFE_PAGES_SECT0B;
              end else begin
                arr_first_page_r <= 11'h000; // RL9
                arr_page_count_r <= `SFE_PAGES_BLOCK;
              end
              tmr_cycles_r <= SECTOR_ERASE_CYCLES; // RL10
              arr_erase_go_r <= 1'b1;
              tmr_load_r <= 1'b1;
              st_r <= ST_ERASE;
            end else if (is_prog) begin
              // Built-in erase of the target page comes first.
              arr_first_page_r <= pg; // RL19
              arr_page_count_r <= 12'h001;
              tmr_cycles_r <= PAGE_ERASE_CYCLES;
              prog_pending_r <= 1'b1;
              arr_erase_go_r <= 1'b1;
              tmr_load_r <= 1'b1;
              st_r <= ST_ERASE;
            end
          end
        end
        ST_ERASE: begin
          if (tmr_done) begin
            if (prog_pending_r) begin
              prog_pending_r <= 1'b0;
              tmr_cycles_r <= PAGE_PROG_CYCLES; // RL19
              arr_prog_go_r <= 1'b1;
              tmr_load_r <= 1'b1;
              st_r <= ST_PROG;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_PROG: begin
          if (tmr_done) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Timer for the self-timed phases.
  sfe_timer #(
    .WIDTH(32)
  ) u_timer (
    .clock(clock),
    .reset(reset),
    .load(tmr_load_r),
    .load_cycles(tmr_cycles_r),
    .running(),
    .done_r(tmr_done)
  );

endmodule // sfe_sequencer

`default_nettype wire

// *** rtl/sfe_timer.v ***
// Down-counting timer that measures one self-timed array phase.
`timescale 1ns/1ps
`default_nettype none

module sfe_timer #(
  parameter WIDTH = 32
) (
  // Clock and reset.
  input wire clock,
  input wire reset,
  // Control.
  input wire load,
  input wire [WIDTH-1:0] load_cycles,
  // Status.
  output wire running,
  output reg done_r
);

  reg [WIDTH-1:0] cnt_r;

  // Count down from the loaded figure and pulse done on the final cycle.
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r <= {WIDTH{1'b0}};
      done_r <= 1'b0;
    end else if (load) begin
      cnt_r <= load_cycles;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
      if (cnt_r != {WIDTH{1'b0}}) begin
        cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign running = (cnt_r != {WIDTH{1'b0}});

endmodule // sfe_timer

`default_nettype wire

// *** verif/sfe_checker_properties.sv ***
// Port-level assertions for the erase and program sequencer.
`timescale 1ns/1ps
`default_nettype none
module sfe_checker #(
  parameter int PAGE_ERASE_CYCLES = 20
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Configuration.
  input wire logic binary_page_mode,
  input wire logic [8:0] sect_prot_mask,
  input wire logic [8:0] sect_lock_mask,
  // Status, buffer and array outputs.
  input wire logic status_busy_r,
  input wire logic prot_active_r,
  input wire logic buf_wr_en_r,
  input wire logic [8:0] buf_wr_addr_r,
  input wire logic arr_erase_go_r,
  input wire logic arr_prog_go_r,
  input wire logic [10:0] arr_first_page_r,
  input wire logic [11:0] arr_page_count_r,
  input wire logic [8:0] arr_skip_mask_r
);
  localparam int PE_LAST = PAGE_ERASE_CYCLES + 8;
  // All checks use the system clock and stand down in reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  busy_held_a: assert property (arr_erase_go_r |-> status_busy_r [*8])
    else $error("busy not held after an erase launch");
  block_align_a: assert property (arr_erase_go_r && arr_page_count_r == 12'h008 |-> arr_first_page_r[2:0] == 3'h0)
    else $error("eight-page erase not aligned");
  sector_pick_a: assert property (arr_erase_go_r && arr_page_count_r == 12'h100 |->
    arr_first_page_r[7:0] == 8'h0 && arr_first_page_r[10:8] != 3'h0)
    else $error("sector erase start wrong");
  sector_low_a: assert property (arr_erase_go_r && arr_page_count_r == 12'h0f8 |-> arr_first_page_r == 11'h008)
    else $error("sub-sector erase start wrong");
  chip_skip_a: assert property (arr_erase_go_r && arr_page_count_r == 12'h800 |->
    arr_first_page_r == 11'h0 && arr_skip_mask_r == (sect_lock_mask | (prot_active_r ? sect_prot_mask : 9'h0)))
    else $error("chip erase skip mask wrong");
  prog_follow_a: assert property (arr_erase_go_r && arr_page_count_r == 12'h001 |->
    ##[PAGE_ERASE_CYCLES:PE_LAST] arr_prog_go_r)
    else $error("program phase missing after page erase");
  prot_frozen_a: assert property (status_busy_r && $past(status_busy_r) |-> $stable(prot_active_r))
    else $error("protection changed while busy");
  buf_range_a: assert property (buf_wr_en_r |-> !status_busy_r && buf_wr_addr_r <= (binary_page_mode ? 9'h0ff : 9'h107))
    else $error("buffer write out of range or while busy");
endmodule // sfe_checker
`default_nettype wire

// *** verif/sfe_host_model.sv ***
// Host controller model that clocks command frames into the sequencer.
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
  // Clock and device status.
  input wire logic clock,
  input wire logic status_busy_r,
  // Serial link pins.
  output logic cs_n,
  output logic sck,
  output logic si
);
  // The link idles deselected with the serial clock parked low.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Sends one frame MSB first, dropping cut bits at its end; rude skips the wait for idle.
  task automatic send(input logic [7:0] b[$], input int cut, input bit rude);
    for (int n = 0; n < 9000 && !rude && status_busy_r !== 1'b0; n++) @(posedge clock);
    cs_n <= 1'b0;
    for (int i = 0; i < b.size() * 8 - cut; i++) begin
      si <= b[i / 8][7 - i % 8];
      repeat (4) @(posedge clock);
      sck <= 1'b1;
      repeat (4) @(posedge clock);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (6) @(posedge clock);
  endtask
endmodule // sfe_host_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the erase and program sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, reset, wp_n, binary_page_mode, sect_prot_sw_en;
  logic [8:0] sect_prot_mask, sect_lock_mask;
  logic [31:0] rng, v;
  logic [31:0] eq[$], pq[$], wq[$], sq[$];
  int fail_count, total_checks, cycles;
  wire cs_n, sck, si, status_busy_r, prot_active_r, buf_wr_en_r, buf_wr_sel_r;
  wire arr_erase_go_r, arr_prog_go_r, arr_buf_sel_r;
  wire [8:0] buf_wr_addr_r, arr_skip_mask_r;
  wire [7:0] buf_wr_data_r;
  wire [10:0] arr_first_page_r;
  wire [11:0] arr_page_count_r;
  sfe_host_model i_sfe_host_model (.clock, .status_busy_r, .cs_n, .sck, .si);
  sfe_sequencer #(.BLOCK_ERASE_CYCLES(20), .SECTOR_ERASE_CYCLES(20), .CHIP_ERASE_CYCLES(3000),
    .PAGE_ERASE_CYCLES(20), .PAGE_PROG_CYCLES(20)) i_sfe_sequencer (.clock, .reset, .cs_n, .sck, .si, .wp_n,
    .binary_page_mode, .sect_prot_sw_en, .sect_prot_mask, .sect_lock_mask, .status_busy_r, .prot_active_r,
    .buf_wr_en_r, .buf_wr_sel_r, .buf_wr_addr_r, .buf_wr_data_r, .arr_erase_go_r, .arr_prog_go_r,
    .arr_first_page_r, .arr_page_count_r, .arr_skip_mask_r, .arr_buf_sel_r);
  // System clock at 100 MHz.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Xorshift source for addresses, data and masks.
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // An empty queue yields all ones so that an unexpected result mismatches.
  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return q.size() ? q.pop_front() : '1;
  endfunction
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Checks each launch and buffer write against the queued expectations.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      results();
    end
    if (arr_erase_go_r === 1'b1) chk("erase", pop(eq), {arr_first_page_r, arr_page_count_r});
    if (arr_erase_go_r === 1'b1 && arr_page_count_r === 12'h800) chk("skip", pop(sq), arr_skip_mask_r);
    if (arr_prog_go_r === 1'b1) chk("program", pop(pq), {arr_buf_sel_r, arr_first_page_r});
    if (buf_wr_en_r === 1'b1) chk("write", pop(wq), {buf_wr_sel_r, buf_wr_addr_r, buf_wr_data_r});
  end
  // Builds one frame, queues what it should cause, then sends it.
  task automatic cmd(input logic [7:0] op, input logic [31:0] p, q, input int nd, cut);
    logic [7:0] b[$];
    logic [31:0] r;
    logic [23:0] a;
    logic [10:0] pg;
    logic [8:0] pos;
    pg = p[10:0];
    r = rnd();
    a = binary_page_mode ? {r[4:0], pg, q[7:0]} : {r[3:0], pg, q[8:0]};
    pos = binary_page_mode ? {1'b0, q[7:0]} : q[8:0];
    if (op == 8'hc7) b = '{8'hc7, 8'h94, 8'h80, 8'h9a};
    else b = '{op, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < nd; i++) begin
      r = rnd();
      b.push_back(r[7:0]);
      if (op[7:4] == 4'h8) begin
        wq.push_back({op[2], pos, r[7:0]});
        pos = (pos == (binary_page_mode ? 9'h0ff : 9'h107)) ? 9'h0 : pos + 9'h1;
      end
    end
    if (cut == 0) begin
      if (op == 8'h50) eq.push_back({pg[10:3], 3'h0, 12'h008});
      if (op == 8'h7c && pg[10:8] != 3'h0) eq.push_back({pg[10:8], 8'h0, 12'h100});
      if (op == 8'h7c && pg[10:8] == 3'h0) eq.push_back(pg[3] ? {11'h8, 12'h0f8} : {11'h0, 12'h008});
      if (op[7:4] == 4'h8) eq.push_back({pg, 12'h001});
      if (op[7:4] == 4'h8) pq.push_back({op[2], pg});
      if (op == 8'hc7) eq.push_back({11'h0, 12'h800});
      if (op == 8'hc7) sq.push_back(sect_lock_mask | (sect_prot_sw_en || !wp_n ? sect_prot_mask : 9'h0));
    end
    i_sfe_host_model.send(b, cut, 1'b0);
  endtask
  // Waits a bounded time for busy to reach a level.
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 9000 && status_busy_r !== lvl; n++) @(posedge clock);
    if (status_busy_r !== lvl) chk("busy", lvl, status_busy_r);
  endtask
  // Main sequence.
  initial begin
    rng = 32'h17d6e4c5;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    reset = 1'b1;
    wp_n = 1'b1;
    binary_page_mode = 1'b0;
    sect_prot_sw_en = 1'b0;
    sect_prot_mask = 9'h0;
    sect_lock_mask = 9'h0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    // Every block erase, sector erase and program command in both formats, with boundary pages and wrapping writes.
    for (int m = 0; m < 2; m++) begin
      binary_page_mode <= m[0];
      @(posedge clock);
      cmd(8'h50, rnd(), rnd(), 0, 0);
      cmd(8'h50, 32'h7ff, 0, 0, 0);
      cmd(8'h7c, 32'h007, rnd(), 0, 0);
      cmd(8'h7c, 32'h00c, rnd(), 0, 0);
      for (int s = 1; s < 8; s++) cmd(8'h7c, s * 256 + 32'h5a, rnd(), 0, 0);
      cmd(8'h82, rnd(), m ? 32'h0fd : 32'h105, 5, 0);
      cmd(8'h85, rnd(), rnd() % 256, 3, 0);
    end
    // Chip erase with trailing bytes, a frame while busy and write protect raised mid-erase.
    wait_busy(1'b0);
    v = rnd();
    sect_prot_sw_en <= v[0];
    sect_prot_mask <= v[9:1];
    sect_lock_mask <= v[18:10];
    @(posedge clock);
    cmd(8'hc7, 0, 0, 2, 0);
    wait_busy(1'b1);
    wp_n <= 1'b0;
    i_sfe_host_model.send('{8'h50, 8'h00, 8'h00, 8'h00}, 0, 1'b1);
    chk("deferred", v[0], prot_active_r);
    wait_busy(1'b0);
    repeat (8) @(posedge clock);
    chk("protection", 1, prot_active_r);
    wp_n <= 1'b1;
    // Frames cut mid-byte, short of address bytes or with an unknown opcode launch nothing.
    cmd(8'h50, 0, 0, 0, 3);
    cmd(8'h7c, 0, 0, 0, 8);
    cmd(8'h5a, 0, 0, 0, 0);
    repeat (60) @(posedge clock);
    chk("pending", 0, eq.size() + pq.size() + wq.size() + sq.size());
    results();
  end
endmodule // testbench
bind sfe_sequencer sfe_checker #(.PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES)) i_sfe_checker (.clock, .reset,
  .binary_page_mode, .sect_prot_mask, .sect_lock_mask, .status_busy_r, .prot_active_r, .buf_wr_en_r,
  .buf_wr_addr_r, .arr_erase_go_r, .arr_prog_go_r, .arr_first_page_r, .arr_page_count_r, .arr_skip_mask_r);
`default_nettype wire
